//--- core/sysref_pkg.sv
package sysref_pkg;

  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int NUM_OUT = 12;
  localparam int CNT_W = 16;
  localparam int AW = 8;
  localparam int CTRL_W = 7;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [AW-1:0] ADDR_PULSE = 8'h04;
  localparam logic [AW-1:0] ADDR_PAUSE = 8'h08;
  localparam logic [AW-1:0] ADDR_OUTSEL = 8'h0c;
  localparam logic [AW-1:0] ADDR_DRVEN = 8'h10;
  localparam logic [AW-1:0] ADDR_HALFDIV = 8'h14;
  localparam logic [AW-1:0] ADDR_STATUS = 8'h18;

  // ----------------------------------------
  // control and status fields
  // ----------------------------------------
  localparam int CTRL_INIT = 0;
  localparam int CTRL_CLEAR = 1;
  localparam int CTRL_TODSEL = 2;
  localparam int CTRL_PRIME = 3;
  localparam int CTRL_ORD_LO = 4;
  localparam int CTRL_GROUP = 6;
  localparam int STS_BUSY = 0;
  localparam int STS_PAUSE = 1;
  localparam int STS_GATE = 2;
  localparam int STS_UNSUP = 3;
  localparam int STS_MODE_LO = 8;
  localparam int STS_CNT_LO = 16;

  // ----------------------------------------
  // reset values and constants
  // ----------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [CNT_W-1:0] PULSE_RST = 16'h0001;
  localparam logic [CNT_W-1:0] PAUSE_RST = 16'h0001;
  localparam logic [CNT_W-1:0] HALFDIV_RST = 16'h0004;
  localparam logic [NUM_OUT-1:0] OUTSEL_RST = 12'h000;
  localparam logic [NUM_OUT-1:0] DRVEN_RST = 12'h000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] ARM_WAIT_SLOW = 2'h1;
  localparam logic [1:0] ARM_WAIT_FAST = 2'h0;

  // ----------------------------------------
  // modes
  // ----------------------------------------
  localparam logic [2:0] MODE_SW_CNT = 3'h0;
  localparam logic [2:0] MODE_SW_PP = 3'h1;
  localparam logic [2:0] MODE_SW_CONT = 3'h2;
  localparam logic [2:0] MODE_PIN_CLR = 3'h3;
  localparam logic [2:0] MODE_EXT_CNT = 3'h4;
  localparam logic [2:0] MODE_FALL_CNT = 3'h5;
  localparam logic [2:0] MODE_EXT_CONT = 3'h6;
  localparam logic [2:0] MODE_INV_CONT = 3'h7;

  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_RUN, ST_PAUSE} state_t;
  typedef enum logic [1:0] {EV_COUNTED, EV_CONT, EV_PP} ev_t;

  typedef struct packed {
    ev_t kind;
    logic start;
    logic stop;
    logic unsup;
  } trig_t;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] pulse_cfg;
    logic [CNT_W-1:0] pause_cfg;
    logic [CNT_W-1:0] half_div;
    logic [NUM_OUT-1:0] out_sel;
    logic [NUM_OUT-1:0] drv_en;
    logic awready;
    logic wready;
    logic arready;
    logic aw_got;
    logic [AW-1:0] aw_addr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic gpio_s1;
    logic gpio_s2;
    logic gpio_prev;
    logic tod_s1;
    logic tod_s2;
    logic tod_prev;
    logic init_prev;
    logic clear_prev;
    logic [CNT_W-1:0] div_cnt;
    logic phase;
    state_t st;
    logic [1:0] wait_cnt;
    logic [CNT_W-1:0] cnt;
    logic stop_pend;
    logic gate;
    logic [NUM_OUT-1:0] sysref_out;
    logic [NUM_OUT-1:0] drv_oe;
  } core_t;

endpackage : sysref_pkg

//--- core/sysref_event_controller.sv
// Function
// - only whole 50/50 SYSREF periods appear, never a runt pulse
// - one controller and one mode serve every SYSREF output
// - mode number is group bit above two-bit ordering field
// - continuous event pulses from start trigger until stop trigger
// - counted event stops by itself after the programmed pulse count
// - pulse/pause repeats pulses then pauses until stop trigger
// - mode 0: counted, started by initiate bit rising
// - mode 1: pulse/pause, initiate bit rise starts, fall stops
// - mode 2: continuous, initiate bit rise starts, fall stops
// - mode 3: continuous, pin rise starts, clear bit rise stops
// - mode 4: counted, pin rise or time-compare rise starts
// - mode 5: counted on pin fall; unsupported with time-compare select
// - mode 6: continuous, pin or time-compare rise to fall
// - mode 7: continuous, pin fall to rise; unsupported with select
// - time-compare select matters only in modes 4 to 7
// - each output with its select bit set carries SYSREF
// - outside events SYSREF drivers off, others follow driver enable
// - drivers enabled only for whole internal SYSREF clock periods
// - event starts on second SYSREF clock rise, first with option
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.
module sysref_event_controller
  import sysref_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic gpio1_in,
  input wire logic time_cmp_evt,
  output logic [NUM_OUT-1:0] sysref_out,
  output logic [NUM_OUT-1:0] drv_oe
);

  core_t r_reg;
  core_t r_next;

  // ----------------------------------------
  // trigger edges
  // ----------------------------------------
  logic [2:0] mode;
  logic init_rise;
  logic init_fall;
  logic clear_rise;
  logic pin_rise;
  logic pin_fall;
  logic tod_rise;
  logic tod_fall;
  logic [CNT_W-1:0] half;
  logic tick;
  logic rise;
  trig_t trig;

  assign mode = r_reg.ctrl[CTRL_GROUP:CTRL_ORD_LO];
  assign init_rise = r_reg.ctrl[CTRL_INIT] && !r_reg.init_prev;
  assign init_fall = !r_reg.ctrl[CTRL_INIT] && r_reg.init_prev;
  assign clear_rise = r_reg.ctrl[CTRL_CLEAR] && !r_reg.clear_prev;
  // edges only look past the second sync stage
  assign pin_rise = r_reg.gpio_s2 && !r_reg.gpio_prev;
  assign pin_fall = !r_reg.gpio_s2 && r_reg.gpio_prev;
  assign tod_rise = r_reg.tod_s2 && !r_reg.tod_prev;
  assign tod_fall = !r_reg.tod_s2 && r_reg.tod_prev;

  // a zero divisor would stall the clock, so treat it as one
  assign half = (r_reg.half_div == '0) ? 16'h0001 : r_reg.half_div;
  assign tick = (r_reg.div_cnt >= half - 16'h0001);
  assign rise = tick && !r_reg.phase;

  function automatic trig_t decode(input logic [2:0] m, input logic tsel);
    trig_t t;
    t = '{kind: EV_CONT, start: 1'b0, stop: 1'b0, unsup: 1'b0};
    unique case (m)
      MODE_SW_CNT: begin
        t.kind = EV_COUNTED;
        t.start = init_rise;
      end
      MODE_SW_PP: begin
        t.kind = EV_PP;
        t.start = init_rise;
        t.stop = init_fall;
      end
      MODE_SW_CONT: begin
        t.start = init_rise;
        t.stop = init_fall;
      end
      MODE_PIN_CLR: begin
        t.start = pin_rise;
        t.stop = clear_rise;
      end
      MODE_EXT_CNT: begin
        t.kind = EV_COUNTED;
        t.start = tsel ? tod_rise : pin_rise;
      end
      MODE_FALL_CNT: begin
        t.kind = EV_COUNTED;
        t.start = pin_fall;
        t.unsup = tsel;
      end
      MODE_EXT_CONT: begin
        t.start = tsel ? tod_rise : pin_rise;
        t.stop = tsel ? tod_fall : pin_fall;
      end
      MODE_INV_CONT: begin
        t.start = pin_fall;
        t.stop = pin_rise;
        t.unsup = tsel;
      end
    endcase
    return t;
  endfunction : decode

  always_comb trig = decode(mode, r_reg.ctrl[CTRL_TODSEL]);

  // ----------------------------------------
  // register access helpers
  // ----------------------------------------
  function automatic logic hit(input logic [AW-1:0] a);
    return a == ADDR_CTRL || a == ADDR_PULSE || a == ADDR_PAUSE ||
           a == ADDR_OUTSEL || a == ADDR_DRVEN || a == ADDR_HALFDIV ||
           a == ADDR_STATUS;
  endfunction : hit

  function automatic logic [31:0] rd_word(input logic [AW-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      ADDR_CTRL: v = 32'(r_reg.ctrl);
      ADDR_PULSE: v = 32'(r_reg.pulse_cfg);
      ADDR_PAUSE: v = 32'(r_reg.pause_cfg);
      ADDR_OUTSEL: v = 32'(r_reg.out_sel);
      ADDR_DRVEN: v = 32'(r_reg.drv_en);
      ADDR_HALFDIV: v = 32'(r_reg.half_div);
      ADDR_STATUS: begin
        v[STS_BUSY] = (r_reg.st != ST_IDLE);
        v[STS_PAUSE] = (r_reg.st == ST_PAUSE);
        v[STS_GATE] = r_reg.gate;
        v[STS_UNSUP] = trig.unsup;
        v[STS_MODE_LO +: 3] = mode;
        v[STS_CNT_LO +: CNT_W] = r_reg.cnt;
      end
      default: v = '0;
    endcase
    return v;
  endfunction : rd_word

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] v;
    v = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        v[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return v;
  endfunction : merge

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    logic [31:0] wr;
    wr = merge(rd_word(r_reg.aw_addr), r_reg.wdata, r_reg.wstrb);
    r_next = r_reg;

    // two-stage synchronisers
    r_next.gpio_s1 = gpio1_in;
    r_next.gpio_s2 = r_reg.gpio_s1;
    r_next.gpio_prev = r_reg.gpio_s2;
    r_next.tod_s1 = time_cmp_evt;
    r_next.tod_s2 = r_reg.tod_s1;
    r_next.tod_prev = r_reg.tod_s2;
    r_next.init_prev = r_reg.ctrl[CTRL_INIT];
    r_next.clear_prev = r_reg.ctrl[CTRL_CLEAR];

    // write channel: address and data in either order
    if (awvalid && r_reg.awready) begin
      r_next.aw_got = 1'b1;
      r_next.aw_addr = awaddr;
    end
    if (wvalid && r_reg.wready) begin
      r_next.w_got = 1'b1;
      r_next.wdata = wdata;
      r_next.wstrb = wstrb;
    end
    if (r_reg.bvalid && bready) begin
      r_next.bvalid = 1'b0;
    end
    if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
      r_next.aw_got = 1'b0;
      r_next.w_got = 1'b0;
      r_next.bvalid = 1'b1;
      r_next.bresp = hit(r_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      case (r_reg.aw_addr)
        ADDR_CTRL: r_next.ctrl = wr[CTRL_W-1:0];
        ADDR_PULSE: r_next.pulse_cfg = wr[CNT_W-1:0];
        ADDR_PAUSE: r_next.pause_cfg = wr[CNT_W-1:0];
        ADDR_OUTSEL: r_next.out_sel = wr[NUM_OUT-1:0];
        ADDR_DRVEN: r_next.drv_en = wr[NUM_OUT-1:0];
        ADDR_HALFDIV: r_next.half_div = wr[CNT_W-1:0];
        default: ;
      endcase
    end
    r_next.awready = !r_next.aw_got && !r_next.bvalid;
    r_next.wready = !r_next.w_got && !r_next.bvalid;

    // read channel
    if (r_reg.rvalid && rready) begin
      r_next.rvalid = 1'b0;
    end
    if (arvalid && r_reg.arready) begin
      r_next.rvalid = 1'b1;
      r_next.rdata = rd_word(araddr);
      r_next.rresp = hit(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    r_next.arready = !r_next.rvalid;

    // internal SYSREF clock, high and low halves of equal length
    if (tick) begin
      r_next.div_cnt = '0;
      r_next.phase = !r_reg.phase;
    end else begin
      r_next.div_cnt = r_reg.div_cnt + 16'h0001;
    end

    // a stop in run or pause is held until the next period boundary acts on it; in arm it acts at once
    r_next.stop_pend = (r_reg.stop_pend || trig.stop) &&
                       (r_reg.st == ST_RUN || r_reg.st == ST_PAUSE);

    // gate only moves on a rising edge of the SYSREF clock
    unique case (r_reg.st)
      ST_IDLE: begin
        if (trig.start && !trig.unsup) begin
          r_next.st = ST_ARM;
          r_next.wait_cnt = r_reg.ctrl[CTRL_PRIME] ? ARM_WAIT_FAST
                                                   : ARM_WAIT_SLOW;
        end
      end
      ST_ARM: begin
        if (trig.stop) begin
          r_next.st = ST_IDLE;
        end else if (rise) begin
          if (r_reg.wait_cnt != '0) begin
            r_next.wait_cnt = r_reg.wait_cnt - 2'h1;
          end else if (trig.kind != EV_CONT && r_reg.pulse_cfg == '0) begin
            r_next.st = ST_IDLE;
          end else begin
            r_next.st = ST_RUN;
            r_next.gate = 1'b1;
            r_next.cnt = 16'h0001;
          end
        end
      end
      ST_RUN: begin
        if (rise) begin
          unique case (trig.kind)
            EV_COUNTED: begin
              if (r_reg.cnt >= r_reg.pulse_cfg) begin
                r_next.st = ST_IDLE;
                r_next.gate = 1'b0;
              end else begin
                r_next.cnt = r_reg.cnt + 16'h0001;
              end
            end
            EV_CONT: begin
              if (r_reg.stop_pend) begin
                r_next.st = ST_IDLE;
                r_next.gate = 1'b0;
              end
            end
            EV_PP: begin
              if (r_reg.stop_pend) begin
                r_next.st = ST_IDLE;
                r_next.gate = 1'b0;
              end else if (r_reg.cnt >= r_reg.pulse_cfg) begin
                r_next.cnt = 16'h0001;
                if (r_reg.pause_cfg != '0) begin
                  r_next.st = ST_PAUSE;
                  r_next.gate = 1'b0;
                end
              end else begin
                r_next.cnt = r_reg.cnt + 16'h0001;
              end
            end
            default: begin
              r_next.st = ST_IDLE;
              r_next.gate = 1'b0;
            end
          endcase
        end
      end
      ST_PAUSE: begin
        if (rise) begin
          if (r_reg.stop_pend || trig.kind != EV_PP) begin
            r_next.st = ST_IDLE;
          end else if (r_reg.cnt >= r_reg.pause_cfg) begin
            r_next.st = ST_RUN;
            r_next.gate = 1'b1;
            r_next.cnt = 16'h0001;
          end else begin
            r_next.cnt = r_reg.cnt + 16'h0001;
          end
        end
      end
    endcase

    // every selected output shares the one gate
    r_next.sysref_out = r_next.out_sel &
                        {NUM_OUT{r_next.gate && r_next.phase}};
    r_next.drv_oe = (r_next.out_sel & {NUM_OUT{r_next.gate}}) |
                    (~r_next.out_sel & r_next.drv_en);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_reg <= '0;
      r_reg.ctrl <= CTRL_RST;
      r_reg.pulse_cfg <= PULSE_RST;
      r_reg.pause_cfg <= PAUSE_RST;
      r_reg.half_div <= HALFDIV_RST;
      r_reg.out_sel <= OUTSEL_RST;
      r_reg.drv_en <= DRVEN_RST;
      r_reg.st <= ST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  assign awready = r_reg.awready;
  assign wready = r_reg.wready;
  assign bvalid = r_reg.bvalid;
  assign bresp = r_reg.bresp;
  assign arready = r_reg.arready;
  assign rvalid = r_reg.rvalid;
  assign rdata = r_reg.rdata;
  assign rresp = r_reg.rresp;
  assign sysref_out = r_reg.sysref_out;
  assign drv_oe = r_reg.drv_oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence pp_burst_end;
    r_reg.st == ST_RUN && trig.kind == EV_PP && rise &&
    !r_reg.stop_pend && r_reg.cnt >= r_reg.pulse_cfg &&
    r_reg.pause_cfg != '0;
  endsequence

  sequence wr_both_taken;
    awvalid && r_reg.awready && wvalid && r_reg.wready;
  endsequence

  gate_whole_a: assert property (
    $changed(r_reg.gate) |-> $past(rise))
    else $error("gate moved off a SYSREF clock rise");

  no_runt_a: assert property (
    $fell(|r_reg.sysref_out) |-> !r_reg.phase && $past(r_reg.phase))
    else $error("SYSREF pulse cut short");

  start_arm_a: assert property (
    r_reg.st == ST_IDLE && trig.start && !trig.unsup |=> r_reg.st == ST_ARM)
    else $error("start trigger not taken");

  arm_second_a: assert property (
    r_reg.st == ST_ARM && rise && r_reg.wait_cnt != '0 && !trig.stop
    |=> r_reg.st == ST_ARM && !r_reg.gate)
    else $error("event began on first edge without option");

  counted_end_a: assert property (
    r_reg.st == ST_RUN && trig.kind == EV_COUNTED && rise &&
    r_reg.cnt >= r_reg.pulse_cfg |=> r_reg.st == ST_IDLE && !r_reg.gate)
    else $error("counted event overran");

  cont_keep_a: assert property (
    r_reg.st == ST_RUN && trig.kind == EV_CONT && rise && !r_reg.stop_pend
    |=> r_reg.st == ST_RUN && r_reg.gate)
    else $error("continuous event stopped early");

  pp_pause_a: assert property (
    pp_burst_end |=> r_reg.st == ST_PAUSE ##0 !r_reg.gate)
    else $error("pulse burst not followed by pause");

  unsup_hold_a: assert property (
    r_reg.st == ST_IDLE && trig.unsup |=> r_reg.st == ST_IDLE)
    else $error("unsupported mode started an event");

  oe_idle_a: assert property (
    !r_reg.gate |-> (r_reg.drv_oe & r_reg.out_sel) == '0 &&
    (r_reg.drv_oe & ~r_reg.out_sel) == (r_reg.drv_en & ~r_reg.out_sel))
    else $error("driver enable wrong outside event");

  sel_route_a: assert property (
    r_reg.sysref_out ==
    (r_reg.out_sel & {NUM_OUT{r_reg.gate && r_reg.phase}}))
    else $error("SYSREF routed to unselected output");

  wr_resp_a: assert property (
    wr_both_taken |=> ##1 r_reg.bvalid)
    else $error("write response late");

endmodule : sysref_event_controller

//--- test/sysref_rx_model.sv
module sysref_rx_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sysref_in,
  input wire logic gpio_req,
  output logic gpio1_in,
  output int rises
);
  timeunit 1ns;
  timeprecision 1ps;

  // ------
  // receiver and trigger pin
  // ------
  logic last;
  int hold;

  // the pin only moves after a dwell, so a slow synchroniser never misses it
  always_ff @(posedge aclk) begin
    last <= sysref_in;
    if (!aresetn) begin
      gpio1_in <= 1'b0;
      hold <= 0;
      rises <= 0;
    end else begin
      if (sysref_in && !last) rises <= rises + 1;
      hold <= hold + 1;
      if (gpio_req != gpio1_in && hold >= 4) begin
        gpio1_in <= gpio_req;
        hold <= 0;
      end
    end
  end
endmodule : sysref_rx_model

//--- test/tb_top.sv
module tb_top
  import sysref_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ------
  // stimulus table: mode, select, start, stop, kind, pin level before
  // ------
  localparam logic [23:0] TBL [15] = '{24'h000700, 24'h010700, 24'h100120,
    24'h200110, 24'h210110, 24'h303210, 24'h313210, 24'h403700, 24'h415700,
    24'h504701, 24'h514731, 24'h603410, 24'h615610, 24'h704311, 24'h714331};
  localparam logic [31:0] RV [6] = '{32'(CTRL_RST), 32'(PULSE_RST),
    32'(PAUSE_RST), 32'(OUTSEL_RST), 32'(DRVEN_RST), 32'(HALFDIV_RST)};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
  logic rready = 1'b0, tod = 1'b0, greq = 1'b0, mon = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, gpio;
  logic [AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, seed = 32'h00017524;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic [NUM_OUT-1:0] so, oe, sel, den;
  logic [6:0] cv = 7'h00;
  int miscompares = 0, samples_checked = 0, cyc = 0, hw = 0, H = 4, rises;
  int rt[$];

  sysref_event_controller DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .gpio1_in(gpio), .time_cmp_evt(tod), .sysref_out(so),
    .drv_oe(oe));
  sysref_rx_model rx (.aclk(aclk), .aresetn(aresetn), .sysref_in(so[0]),
    .gpio_req(greq), .gpio1_in(gpio), .rises(rises));

  initial begin
    forever #2 aclk = ~aclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr

  task summarize;
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  task wr(input logic [AW-1:0] a, input logic [31:0] v, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) aw = 1'b0;
      if (wready) w = 1'b0;
      awvalid <= aw;
      wvalid <= w;
    end while (aw || w);
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr

  task rd(input logic [AW-1:0] a, output logic [31:0] v, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd

  task w_ok(input logic [AW-1:0] a, input logic [31:0] v);
    logic [1:0] r;
    wr(a, v, r);
    chk("bresp", r, RESP_OKAY);
  endtask : w_ok

  // trigger actions: software bits go through the bus, pins are held long
  task act(input int c);
    case (c)
      0: cv[CTRL_INIT] = 1'b1;
      1: cv[CTRL_INIT] = 1'b0;
      2: cv[CTRL_CLEAR] = 1'b1;
      3: greq <= 1'b1;
      4: greq <= 1'b0;
      5: tod <= 1'b1;
      6: tod <= 1'b0;
      default: ;
    endcase
    if (c < 3) w_ok(ADDR_CTRL, {25'h0, cv});
    cv[CTRL_CLEAR] = 1'b0;
    tick(12);
  endtask : act

  // ------
  // monitor and timeout
  // ------
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end else if (mon) begin
      if (so[0] && hw == 0) rt.push_back(cyc);
      if (so[0]) chk("oe_on", oe & sel, sel);
      if (so[0]) hw++;
      else if (hw != 0) begin
        chk("high", hw, H);
        hw = 0;
      end
      chk("fanout", so, sel & {NUM_OUT{so[0]}});
      chk("oe_off", oe & ~sel, den & ~sel);
    end
  end

  initial begin
    logic [31:0] d, e;
    logic [1:0] r;
    int n0, n1, P, Q, kd, lat;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i), d, r);
      chk("reset_value", d, RV[i]);
    end
    rd(8'h1c, d, r);
    chk("unmapped_rresp", r, RESP_SLVERR);
    chk("unmapped_rdata", d, 32'h0);
    wr(8'h1c, 32'hffffffff, r);
    chk("unmapped_bresp", r, RESP_SLVERR);
    w_ok(ADDR_STATUS, 32'hffffffff);
    seed = lfsr(seed);
    sel = seed[11:0] | 12'h001;
    seed = lfsr(seed);
    den = seed[11:0];
    w_ok(ADDR_OUTSEL, 32'(sel));
    w_ok(ADDR_DRVEN, 32'(den));
    H = 8;
    w_ok(ADDR_HALFDIV, 32'h8);
    mon = 1'b1;
    for (int p = 0; p < 2; p++) begin
      cv = 7'h00;
      cv[CTRL_PRIME] = p[0];
      w_ok(ADDR_CTRL, {25'h0, cv});
      rt.delete();
      lat = cyc;
      act(0);
      tick(40);
      lat = rt[0] - lat;
      chk("start_lat", p ? lat <= 2*H+8 : lat >= 2*H+2 && lat <= 4*H+10, 1);
    end
    H = 2;
    w_ok(ADDR_HALFDIV, 32'h2);
    for (int i = 0; i < 15; i++) begin
      e = TBL[i];
      seed = lfsr(seed);
      P = 1 + seed[1:0];
      Q = 1 + seed[3:2] % 3;
      w_ok(ADDR_PULSE, P);
      w_ok(ADDR_PAUSE, Q);
      cv = 7'h00;
      w_ok(ADDR_CTRL, 32'h0);
      greq <= e[0];
      tod <= 1'b0;
      tick(12);
      cv[CTRL_GROUP:CTRL_ORD_LO] = e[22:20];
      cv[CTRL_TODSEL] = e[16];
      w_ok(ADDR_CTRL, {25'h0, cv});
      kd = e[7:4];
      rd(ADDR_STATUS, d, r);
      chk("mode", d[STS_MODE_LO +: 3], e[22:20]);
      chk("unsupported", d[STS_UNSUP], kd == 3);
      rt.delete();
      n0 = rises;
      act(e[15:12]);
      tick(60);
      act(e[11:8]);
      tick(40);
      rd(ADDR_STATUS, d, r);
      chk("busy", d[STS_BUSY], 1'b0);
      n1 = rises - n0;
      if (kd == 0) chk("count", n1, P);
      else if (kd == 3) chk("count", n1, 0);
      else chk("ran", n1 > 0, 1);
      n0 = rises;
      tick(30);
      chk("stopped", rises, n0);
      chk("oe_idle", oe & sel, 0);
      for (int j = 1; j < rt.size(); j++)
        chk("gap", rt[j] - rt[j-1], 2*H*((kd == 2 && j % P == 0) ? Q+1 : 1));
    end
    summarize();
  end
endmodule : tb_top
